/* File: hw/edsc_pkg.sv */
// package for the scrubbing-memory host controller: register map, pin bundles, timing
// assumes a 10 MHz mclk and a device with no clock or reset pin of its own
package edsc_pkg;
	// wishbone register byte offsets
	localparam logic [3:0] EDSC_REG_CTRL = 4'h0;
	localparam logic [3:0] EDSC_REG_ADDR = 4'h4;
	localparam logic [3:0] EDSC_REG_WDATA = 4'h8;
	localparam logic [3:0] EDSC_REG_RDATA = 4'hC;
	// control word field positions
	localparam int EDSC_CTRL_GO = 0;
	localparam int EDSC_CTRL_WRITE = 1;
	localparam int EDSC_CTRL_CREG = 2;
	localparam int EDSC_CTRL_DIE_LO = 4;
	// status field positions (read from the control offset)
	localparam int EDSC_STAT_BUSY = 8;
	localparam int EDSC_STAT_UNCORR = 9;
	localparam int EDSC_STAT_SCRUBBING = 10;
	localparam int EDSC_STAT_WARNED = 11;
	// widths
	localparam int EDSC_AW = 19;
	localparam int EDSC_DW = 32;
	localparam int EDSC_NDIE = 2;
	// timing in ns, and cycles at the 100 ns clock period
	localparam int EDSC_CLK_NS = 100;
	localparam int EDSC_READ_CYCLE_NS = 20;
	localparam int EDSC_FLOAT_NS = 10;
	localparam int EDSC_READ_CYC = (EDSC_READ_CYCLE_NS + EDSC_CLK_NS - 1) / EDSC_CLK_NS;
	localparam int EDSC_FLOAT_CYC = (EDSC_FLOAT_NS + EDSC_CLK_NS - 1) / EDSC_CLK_NS;
	localparam int EDSC_KEY_LEN = 4;
	// reset values
	localparam logic [31:0] EDSC_RST_WORD = 32'h0000_0000;
	// address key sequence leading to the control register
	localparam logic [18:0] EDSC_KEY0 = 19'h0_5555;
	localparam logic [18:0] EDSC_KEY1 = 19'h2_AAAA;
	localparam logic [18:0] EDSC_KEY2 = 19'h0_3333;
	localparam logic [18:0] EDSC_KEY3 = 19'h4_CCCC;
	localparam logic [18:0] EDSC_CREG_RD_ODD = 19'h0_0200;
	localparam logic [18:0] EDSC_CREG_RD_EVEN = 19'h0_0004;

	// pins driven toward the memory
	typedef struct packed {
		logic [EDSC_NDIE-1:0] selectN;
		logic writeN;
		logic driveN;
		logic [EDSC_AW-1:0] addr;
		logic [EDSC_DW-1:0] dq;
		logic dqOe;
		logic uncorrOut;
		logic uncorrOe;
	} edsc_pins_t;

	// pins seen from the memory
	typedef struct packed {
		logic [EDSC_DW-1:0] dq;
		logic uncorr;
		logic scrubN;
		logic warnN;
	} edsc_sense_t;

	typedef enum {EDSC_IDLE, EDSC_WAITSCRUB, EDSC_KEY, EDSC_SETUP, EDSC_FLOAT, EDSC_HOLD, EDSC_DONE} edsc_state_t;
endpackage : edsc_pkg

/* File: hw/edsc_sync.sv */
// two-flop synchroniser for a bundle of asynchronous pin levels
// assumes inputs come straight from pins outside the mclk domain
`timescale 1ns/10ps
module edsc_sync #(
	parameter int W = 1
) (
	// clock and reset
	input wire logic mclk,
	input wire logic resetn,
	// pins and result
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	logic [W-1:0] stage1;

	// first stage is read only by the second
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			stage1 <= '0;
			dout <= '0;
		end else begin
			stage1 <= din;
			dout <= stage1;
		end
	end
endmodule : edsc_sync

/* File: hw/edsc_wb_regs.sv */
// classic wishbone slave holding the controller's command registers; status and read data come in from the engine
// assumes a single-cycle classic master; ack comes one cycle after the strobe
`timescale 1ns/10ps
module edsc_wb_regs (
	// clock and reset
	input wire logic mclk,
	input wire logic resetn,
	// wishbone slave
	input wire logic wbCyc,
	input wire logic wbStb,
	input wire logic wbWe,
	input wire logic [3:0] wbAdr,
	input wire logic [3:0] wbSel,
	input wire logic [31:0] wbDatW,
	output logic [31:0] wbDatR,
	output logic wbAck,
	// to the engine
	output logic goPulse,
	output logic [31:0] ctrlWord,
	output logic [31:0] addrWord,
	output logic [31:0] wdataWord,
	input wire logic [31:0] statusWord,
	input wire logic [31:0] rdataWord
);
	logic [31:0] next_ctrl;
	logic [31:0] next_addr;
	logic [31:0] next_wdata;
	wire logic take = wbCyc && wbStb && !wbAck;
	wire logic wrTake = take && wbWe;
	wire logic [31:0] mask = {{8{wbSel[3]}}, {8{wbSel[2]}}, {8{wbSel[1]}}, {8{wbSel[0]}}};
	wire logic [31:0] rdMux = (wbAdr == edsc_pkg::EDSC_REG_CTRL) ? (ctrlWord | statusWord) :
		(wbAdr == edsc_pkg::EDSC_REG_ADDR) ? addrWord :
		(wbAdr == edsc_pkg::EDSC_REG_WDATA) ? wdataWord :
		(wbAdr == edsc_pkg::EDSC_REG_RDATA) ? rdataWord : 32'h0000_0000;

	// byte-lane merges; the go bit is self-clearing and never stored
	assign next_ctrl = (wrTake && wbAdr == edsc_pkg::EDSC_REG_CTRL) ?
		(((ctrlWord & ~mask) | (wbDatW & mask)) & 32'h0000_00FE) : ctrlWord;
	assign next_addr = (wrTake && wbAdr == edsc_pkg::EDSC_REG_ADDR) ? ((addrWord & ~mask) | (wbDatW & mask)) : addrWord;
	assign next_wdata = (wrTake && wbAdr == edsc_pkg::EDSC_REG_WDATA) ? ((wdataWord & ~mask) | (wbDatW & mask)) : wdataWord;

	// registers, ack and read data
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			ctrlWord <= edsc_pkg::EDSC_RST_WORD;
			addrWord <= edsc_pkg::EDSC_RST_WORD;
			wdataWord <= edsc_pkg::EDSC_RST_WORD;
			wbAck <= 1'b0;
			wbDatR <= 32'h0000_0000;
			goPulse <= 1'b0;
		end else begin
			ctrlWord <= next_ctrl;
			addrWord <= next_addr;
			wdataWord <= next_wdata;
			wbAck <= take;
			wbDatR <= take ? rdMux : 32'h0000_0000;
			goPulse <= wrTake && wbAdr == edsc_pkg::EDSC_REG_CTRL && wbSel[0] && wbDatW[edsc_pkg::EDSC_CTRL_GO];
		end
	end
endmodule : edsc_wb_regs

/* File: hw/edsc_host.sv */
// host controller driving a scrubbing static memory through its pins
// assumes pins pass two flip-flops in; the bench resolves dq and flag wires from the enables
//
// Notes on behaviour
// - never assert two selects together
// - hold read address a full cycle time
// - low flag valid, high flag corrupted
// - keep inputs stable while scrubbing
// - control register reached by address series
// - drive flag high for control-register access
// - wait float time before driving data
`timescale 1ns/10ps
module edsc_host #(
	parameter int READ_CYC = edsc_pkg::EDSC_READ_CYC,
	parameter int FLOAT_CYC = edsc_pkg::EDSC_FLOAT_CYC
) (
	// clock and reset
	input wire logic mclk,
	input wire logic resetn,
	// wishbone slave
	input wire logic wbCyc,
	input wire logic wbStb,
	input wire logic wbWe,
	input wire logic [3:0] wbAdr,
	input wire logic [3:0] wbSel,
	input wire logic [31:0] wbDatW,
	output logic [31:0] wbDatR,
	output logic wbAck,
	// memory pins, outbound
	output logic [edsc_pkg::EDSC_NDIE-1:0] selectN,
	output logic writeN,
	output logic driveN,
	output logic [edsc_pkg::EDSC_AW-1:0] memAddr,
	output logic [edsc_pkg::EDSC_DW-1:0] dqOut,
	output logic dqOe,
	output logic uncorrOut,
	output logic uncorrOe,
	// memory pins, inbound
	input wire logic [edsc_pkg::EDSC_DW-1:0] dqIn,
	input wire logic uncorrectable_error_flag,
	input wire logic scrubN,
	input wire logic warnN
);
	logic goPulse;
	logic [31:0] ctrlWord;
	logic [31:0] addrWord;
	logic [31:0] wdataWord;
	logic [31:0] statusWord;
	logic [31:0] rdataWord;
	edsc_pkg::edsc_sense_t sense;
	edsc_pkg::edsc_pins_t pins;
	edsc_pkg::edsc_pins_t next_pins;
	edsc_pkg::edsc_state_t state;
	edsc_pkg::edsc_state_t next_state;
	logic [7:0] count;
	logic [7:0] next_count;
	logic [1:0] keyIdx;
	logic busyFlag;
	logic uncorrSticky;
	logic [31:0] next_rdata;
	logic [7:0] cmdLatch;
	logic [edsc_pkg::EDSC_AW-1:0] addrLatch;
	logic [31:0] dataLatch;
	logic [7:0] next_cmdLatch;
	logic [edsc_pkg::EDSC_AW-1:0] next_addrLatch;
	logic [31:0] next_dataLatch;

	// register file
	edsc_wb_regs regs (
		.mclk(mclk),
		.resetn(resetn),
		.wbCyc(wbCyc),
		.wbStb(wbStb),
		.wbWe(wbWe),
		.wbAdr(wbAdr),
		.wbSel(wbSel),
		.wbDatW(wbDatW),
		.wbDatR(wbDatR),
		.wbAck(wbAck),
		.goPulse(goPulse),
		.ctrlWord(ctrlWord),
		.addrWord(addrWord),
		.wdataWord(wdataWord),
		.statusWord(statusWord),
		.rdataWord(rdataWord)
	);

	// pin synchronisers; dq and flag are sampled only after the read cycle time has settled
	// the stages reset to a scrub-active level; the wait state simply rides out those two cycles
	edsc_sync #(.W(edsc_pkg::EDSC_DW + 3)) pinSync (
		.mclk(mclk),
		.resetn(resetn),
		.din({dqIn, uncorrectable_error_flag, scrubN, warnN}),
		.dout(sense)
	);

	// command, address and data are captured at go; later register writes wait for the next command
	wire logic loadCmd = (state == edsc_pkg::EDSC_IDLE) && goPulse;
	assign next_cmdLatch = loadCmd ? ctrlWord[7:0] : cmdLatch;
	assign next_addrLatch = loadCmd ? addrWord[edsc_pkg::EDSC_AW-1:0] : addrLatch;
	assign next_dataLatch = loadCmd ? wdataWord : dataLatch;
	// decoded command fields, from the captured copy so a write while busy cannot bend an access
	wire logic cmdWrite = cmdLatch[edsc_pkg::EDSC_CTRL_WRITE];
	wire logic cmdCreg = cmdLatch[edsc_pkg::EDSC_CTRL_CREG];
	wire logic dieSel = cmdLatch[edsc_pkg::EDSC_CTRL_DIE_LO];
	wire logic scrubbing = !sense.scrubN;
	wire logic warned = !sense.warnN;
	wire logic holdDone = (count == 8'h00);
	wire logic [18:0] keyAddr = (keyIdx == 2'h0) ? edsc_pkg::EDSC_KEY0 :
		(keyIdx == 2'h1) ? edsc_pkg::EDSC_KEY1 :
		(keyIdx == 2'h2) ? edsc_pkg::EDSC_KEY2 : edsc_pkg::EDSC_KEY3;
	// read-or-write select bit, odd die uses the high bit
	wire logic [18:0] cregSel = cmdWrite ? 19'h0_0000 :
		(dieSel ? edsc_pkg::EDSC_CREG_RD_ODD : edsc_pkg::EDSC_CREG_RD_EVEN);
	wire logic [edsc_pkg::EDSC_NDIE-1:0] oneSelN = dieSel ? 2'b01 : 2'b10;
	// settle counts in whole clock periods; eight bits keep only a setting's low bits, so one above 255 periods wraps
	wire logic [7:0] readCnt = 8'(READ_CYC);
	wire logic [7:0] floatCnt = 8'(FLOAT_CYC);
	wire logic isWrite = cmdWrite;

	// status sits above the control bits: busy, sticky flag, scrub and warning levels
	assign statusWord = {20'h0_0000, warned, scrubbing, uncorrSticky, busyFlag, 8'h00};
	// current pins as one bundle, the default for the next-value logic
	assign pins = '{selectN: selectN, writeN: writeN, driveN: driveN, addr: memAddr, dq: dqOut,
		dqOe: dqOe, uncorrOut: uncorrOut, uncorrOe: uncorrOe};

	// a read walks idle, wait, setup, hold and done; a write adds the float wait before data;
	// a control-register access first walks the key series with the flag pin driven high;
	// every pin comes from a flip-flop, so a change shows one clock after the state that orders it
	// next state and next pin values
	always_comb begin
		next_state = state;
		next_pins = pins;
		next_count = (count == 8'h00) ? 8'h00 : 8'(count - 8'h01);
		case (state)
			edsc_pkg::EDSC_IDLE: begin
				next_pins.selectN = 2'b11;
				next_pins.writeN = 1'b1;
				next_pins.driveN = 1'b1;
				next_pins.dqOe = 1'b0;
				next_pins.uncorrOe = 1'b0;
				next_pins.uncorrOut = 1'b0;
				if (goPulse) begin
					next_state = edsc_pkg::EDSC_WAITSCRUB;
				end
			end
			edsc_pkg::EDSC_WAITSCRUB: begin
				// no pin moves while a scrub runs or is pending
				// waiting out the warning too costs throughput but never meets a scrub mid-access
				if (!scrubbing && !warned) begin
					next_state = cmdCreg ? edsc_pkg::EDSC_KEY : edsc_pkg::EDSC_SETUP;
					next_pins.addr = cmdCreg ? edsc_pkg::EDSC_KEY0 : addrLatch;
					next_count = readCnt;
				end
			end
			edsc_pkg::EDSC_KEY: begin
				// series of key addresses, one read cycle each
				// a full read cycle per key keeps every address change clean
				next_pins.selectN = oneSelN;
				next_pins.addr = keyAddr;
				next_pins.uncorrOut = 1'b1;
				next_pins.uncorrOe = 1'b1;
				if (holdDone) begin
					next_count = readCnt;
					if (keyIdx == 2'(edsc_pkg::EDSC_KEY_LEN - 1)) begin
						next_pins.addr = cregSel;
						next_state = edsc_pkg::EDSC_SETUP;
					end
				end
			end
			edsc_pkg::EDSC_SETUP: begin
				// one select only, then strobe or drive as the command asks
				next_pins.selectN = oneSelN;
				next_pins.writeN = !isWrite;
				next_pins.driveN = isWrite;
				next_count = isWrite ? floatCnt : readCnt;
				next_state = isWrite ? edsc_pkg::EDSC_FLOAT : edsc_pkg::EDSC_HOLD;
			end
			edsc_pkg::EDSC_FLOAT: begin
				if (holdDone) begin
					next_pins.dq = dataLatch;
					next_pins.dqOe = 1'b1;
					next_count = readCnt;
					next_state = edsc_pkg::EDSC_HOLD;
				end
			end
			edsc_pkg::EDSC_HOLD: begin
				// address held a full read cycle
				if (holdDone) begin
					next_state = edsc_pkg::EDSC_DONE;
				end
			end
			edsc_pkg::EDSC_DONE: begin
				// strobe, drive and select released together
				next_pins.writeN = 1'b1;
				next_pins.driveN = 1'b1;
				next_pins.selectN = 2'b11;
				next_state = edsc_pkg::EDSC_IDLE;
			end
			default: begin
				// unreachable; recovers to idle, which then releases the pins
				next_state = edsc_pkg::EDSC_IDLE;
			end
		endcase
	end

	// a write leaves the last read data in place
	// sample two sync stages after the settle count
	assign next_rdata = (state == edsc_pkg::EDSC_DONE && !isWrite) ? sense.dq : rdataWord;

	// state, counters and pins
	// pins follow the next-value bundle field by field
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			state <= edsc_pkg::EDSC_IDLE;
			count <= 8'h00;
			keyIdx <= 2'h0;
			selectN <= 2'b11;
			writeN <= 1'b1;
			driveN <= 1'b1;
			memAddr <= 19'h0_0000;
			dqOut <= 32'h0000_0000;
			dqOe <= 1'b0;
			uncorrOut <= 1'b0;
			uncorrOe <= 1'b0;
		end else begin
			state <= next_state;
			count <= next_count;
			keyIdx <= (state == edsc_pkg::EDSC_KEY && holdDone) ? 2'(keyIdx + 2'h1) :
				(state == edsc_pkg::EDSC_KEY) ? keyIdx : 2'h0;
			selectN <= next_pins.selectN;
			writeN <= next_pins.writeN;
			driveN <= next_pins.driveN;
			memAddr <= next_pins.addr;
			dqOut <= next_pins.dq;
			dqOe <= next_pins.dqOe;
			uncorrOut <= next_pins.uncorrOut;
			uncorrOe <= next_pins.uncorrOe;
		end
	end

	// status: busy while a command runs; uncorrectable sticks until the next command
	// busy follows the next state, so it falls at the very edge read data lands
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			busyFlag <= 1'b0;
			uncorrSticky <= 1'b0;
			rdataWord <= 32'h0000_0000;
		end else begin
			busyFlag <= (next_state != edsc_pkg::EDSC_IDLE);
			rdataWord <= next_rdata;
			// a control-register read returns the register, not a memory word
			// corrupted-word flag, set wins over clear
			if (state == edsc_pkg::EDSC_DONE && !isWrite && !cmdCreg && sense.uncorr) begin
				uncorrSticky <= 1'b1;
			end else if (goPulse) begin
				uncorrSticky <= 1'b0;
			end
		end
	end

	// captured command, address and write data
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			cmdLatch <= 8'h00;
			addrLatch <= 19'h0_0000;
			dataLatch <= edsc_pkg::EDSC_RST_WORD;
		end else begin
			cmdLatch <= next_cmdLatch;
			addrLatch <= next_addrLatch;
			dataLatch <= next_dataLatch;
		end
	end
endmodule : edsc_host

/* File: verif/edsc_host_properties.sv */
// pin and wishbone assertions for the scrubbing-memory host controller
// assumes the default timing parameters, so a read holds for two cycles
`timescale 1ns/10ps
module edsc_host_props (
	// clock, reset and wishbone
	input wire logic mclk,
	input wire logic resetn,
	input wire logic wbCyc,
	input wire logic wbStb,
	input wire logic [31:0] wbDatR,
	input wire logic wbAck,
	// memory pins
	input wire logic [1:0] selectN,
	input wire logic writeN,
	input wire logic driveN,
	input wire logic [18:0] memAddr,
	input wire logic dqOe,
	input wire logic uncorrOut,
	input wire logic uncorrOe,
	input wire logic scrubN
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!resetn);
	// bus answer timing and idle read data
	ack_pulse_a: assert property (wbCyc && wbStb && !wbAck |=> wbAck ##1 !wbAck) else $error("ack late or long");
	rdata_zero_a: assert property (!wbAck |-> wbDatR == 32'h0000_0000) else $error("read data without ack");
	// memory pin relations
	one_select_a: assert property (selectN != 2'b00) else $error("two selects low");
	no_fight_a: assert property (dqOe |-> driveN) else $error("dq driven while output drive low");
	float_wait_a: assert property ($rose(dqOe) |-> !writeN && $past(writeN) == 1'b0) else $error("dq too early");
	read_hold_a: assert property ($fell(driveN) |-> (!driveN && $stable(memAddr) && selectN != 2'b11)[*2])
		else $error("read not held");
	read_only_a: assert property (!driveN |-> writeN) else $error("drive and strobe both low");
	scrub_idle_a: assert property ($fell(selectN[0]) || $fell(selectN[1]) |-> scrubN)
		else $error("select during scrub");
	flag_high_a: assert property (uncorrOe |-> uncorrOut) else $error("flag driven low");
	key_order_a: assert property (uncorrOe && memAddr == edsc_pkg::EDSC_KEY0 ##1 memAddr != edsc_pkg::EDSC_KEY0
		|-> memAddr == edsc_pkg::EDSC_KEY1) else $error("key order");
endmodule : edsc_host_props
bind edsc_host edsc_host_props u_props (.mclk, .resetn, .wbCyc, .wbStb, .wbDatR, .wbAck, .selectN, .writeN,
	.driveN, .memAddr, .dqOe, .uncorrOut, .uncorrOe, .scrubN);

/* File: verif/edsc_mem_model.sv */
// behavioural model of the scrubbing memory at its pins, one shared 16-word store
// assumes the bench resolves dq and the flag wire, and pulses kick to start a scrub
`timescale 1ns/10ps
module edsc_mem_model #(
	parameter int WARN_CYC = 20,
	parameter int SCRUB_CYC = 8
) (
	// bench timing and control
	input wire logic mclk,
	input wire logic kick,
	// pins from the host
	input wire logic [1:0] selectN,
	input wire logic writeN,
	input wire logic driveN,
	input wire logic [18:0] memAddr,
	input wire logic [31:0] dqW,
	// pins to the host
	output logic [31:0] rdq,
	output logic rdqOe,
	output logic uncorrFlag,
	output logic scrubN = 1'b1,
	output logic warnN = 1'b1
);
	logic [31:0] mem [0:15];
	logic [15:0] bad = 16'h0000;
	logic [31:0] ctrlReg = 32'h0000_0000;
	logic [2:0] keyStep = 3'h0;
	logic [3:0] scrubPtr = 4'h0;
	wire logic sel = selectN != 2'b11 && scrubN;
	wire logic [3:0][18:0] keys = {edsc_pkg::EDSC_KEY3, edsc_pkg::EDSC_KEY2, edsc_pkg::EDSC_KEY1, edsc_pkg::EDSC_KEY0};
	// drive only in a selected read outside a scrub
	assign rdqOe = sel && !driveN && writeN;
	// stored words come out corrected, flag marks bad ones
	assign rdq = keyStep == 3'h5 ? ctrlReg : mem[memAddr[3:0]];
	assign uncorrFlag = keyStep != 3'h5 && bad[memAddr[3:0]];
	// level write, so the last data before the strobe rises wins
	always @(writeN, selectN, dqW, memAddr, scrubN) begin
		if (sel && !writeN && keyStep == 3'h5) ctrlReg = dqW;
		else if (sel && !writeN) begin
			mem[memAddr[3:0]] = dqW;
			bad[memAddr[3:0]] = 1'b0;
		end
	end
	// key series, then one access phase, then plain memory again
	always @(memAddr) begin
		if (keyStep < 3'h4 && memAddr == keys[keyStep[1:0]]) keyStep = keyStep + 3'h1;
		else if (keyStep == 3'h4) keyStep = 3'h5;
		else keyStep = memAddr == edsc_pkg::EDSC_KEY0 ? 3'h1 : 3'h0;
	end
	// warning first, scrub next, both released together
	always @(posedge mclk) begin
		if (kick) begin
			warnN <= 1'b0;
			repeat (WARN_CYC) @(posedge mclk);
			scrubN <= 1'b0;
			scrubPtr <= scrubPtr + 4'h1;
			repeat (SCRUB_CYC) @(posedge mclk);
			scrubN <= 1'b1;
			warnN <= 1'b1;
		end
	end
endmodule : edsc_mem_model

/* File: verif/tb_top.sv */
// self-checking bench: wishbone command sequences against the pin-level memory model
// assumes the design's default timing parameters and a 100 ns mclk
`timescale 1ns/10ps
module tb_top;
	logic mclk = 1'b0;
	logic resetn = 1'b0;
	logic wbCyc = 1'b0;
	logic wbStb = 1'b0;
	logic wbWe = 1'b0;
	logic kick = 1'b0;
	logic lastFlag = 1'b0;
	logic [3:0] wbAdr = 4'h0;
	logic [3:0] wbSel = 4'hF;
	logic [31:0] wbDatW = 32'h0000_0000;
	logic [31:0] lastDq = 32'h0000_0000;
	logic [31:0] wbDatR, dqOut, dqIn, rdq, q, d;
	logic [18:0] memAddr;
	logic [1:0] selectN;
	logic wbAck, writeN, driveN, dqOe, uncorrOut, uncorrOe, flagW, uncorrFlag, rdqOe, scrubN, warnN;
	int failCount = 0;
	int testsRun = 0;
	always #50 mclk = ~mclk;
	// released lines show the inverse of their last level, never a kind guess
	assign dqIn = dqOe ? dqOut : rdqOe ? rdq : ~lastDq;
	assign flagW = uncorrOe ? uncorrOut : rdqOe ? uncorrFlag : ~lastFlag;
	always @(posedge mclk) begin
		lastDq <= dqIn;
		lastFlag <= flagW;
	end
	edsc_host u_edsc_host (.mclk, .resetn, .wbCyc, .wbStb, .wbWe, .wbAdr, .wbSel, .wbDatW, .wbDatR, .wbAck,
		.selectN, .writeN, .driveN, .memAddr, .dqOut, .dqOe, .uncorrOut, .uncorrOe, .dqIn,
		.uncorrectable_error_flag(flagW), .scrubN, .warnN);
	edsc_mem_model u_edsc_mem_model (.mclk, .kick, .selectN, .writeN, .driveN, .memAddr, .dqW(dqIn), .rdq,
		.rdqOe, .uncorrFlag, .scrubN, .warnN);
	// one classic cycle, held until ack is sampled; result lands in q
	task automatic wb(input logic we, input logic [3:0] a, input logic [3:0] s, input logic [31:0] v);
		@(posedge mclk);
		wbCyc <= 1'b1;
		wbStb <= 1'b1;
		wbWe <= we;
		wbAdr <= a;
		wbSel <= s;
		wbDatW <= v;
		do begin
			@(posedge mclk);
		end while (wbAck !== 1'b1);
		q = wbDatR;
		wbCyc <= 1'b0;
		wbStb <= 1'b0;
	endtask : wb
	task automatic chk(input string s, input logic [31:0] g, input logic [31:0] e);
		testsRun++;
		if (g !== e) begin
			failCount++;
			$display("unexpected %s: expected %h seen %h", s, e, g);
		end
	endtask : chk
	// poll busy until the engine is idle, then fetch read data into q; only the watchdog ends a hang
	task automatic await_done();
		do begin
			wb(1'b0, edsc_pkg::EDSC_REG_CTRL, 4'hF, 32'h0);
		end while (q[edsc_pkg::EDSC_STAT_BUSY] !== 1'b0);
		wb(1'b0, edsc_pkg::EDSC_REG_RDATA, 4'hF, 32'h0);
	endtask : await_done
	// load address and data, start, then wait for the result
	task automatic access(input logic [31:0] c, input logic [18:0] a, input logic [31:0] v);
		wb(1'b1, edsc_pkg::EDSC_REG_ADDR, 4'hF, {13'h0000, a});
		wb(1'b1, edsc_pkg::EDSC_REG_WDATA, 4'hF, v);
		wb(1'b1, edsc_pkg::EDSC_REG_CTRL, 4'hF, c | 32'h1);
		repeat (2) @(posedge mclk);
		await_done();
	endtask : access
	task automatic status(input int b, input logic e, input string s);
		wb(1'b0, edsc_pkg::EDSC_REG_CTRL, 4'hF, 32'h0);
		chk(s, {31'h0, q[b]}, {31'h0, e});
	endtask : status
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", testsRun, failCount);
		if (failCount == 0 && testsRun > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : summarize
	initial begin
		repeat (4) @(posedge mclk);
		resetn <= 1'b1;
		chk("idle pins", {25'h0, selectN, writeN, driveN, dqOe, uncorrOe, wbAck}, 32'h78);
		$display("test reset done");
		// write then read on both dies with both polarities
		for (int i = 0; i < 4; i++) begin
			d = i[1] ? 32'h5A5A_C33C : 32'hA5A5_3CC3;
			access({27'h0, i[0], 4'h2}, 19'(i + 5), d);
			access({27'h0, i[0], 4'h0}, 19'(i + 5), 32'h0);
			chk("read data", q, d);
			status(edsc_pkg::EDSC_STAT_UNCORR, 1'b0, "flag clear");
		end
		$display("test write read done");
		// a corrupted word sets the sticky flag and the next command clears it
		u_edsc_mem_model.bad[7] = 1'b1;
		access(32'h0, 19'h7, 32'h0);
		status(edsc_pkg::EDSC_STAT_UNCORR, 1'b1, "flag set");
		access(32'h0, 19'h5, 32'h0);
		chk("good word", q, 32'hA5A5_3CC3);
		status(edsc_pkg::EDSC_STAT_UNCORR, 1'b0, "flag cleared");
		$display("test error flag done");
		// a read asked for during the warning must wait out the scrub; the poll lands inside the scrub
		wb(1'b1, edsc_pkg::EDSC_REG_ADDR, 4'hF, 32'h0000_0008);
		kick <= 1'b1;
		@(posedge mclk);
		kick <= 1'b0;
		repeat (3) @(posedge mclk);
		status(edsc_pkg::EDSC_STAT_WARNED, 1'b1, "warning seen");
		wb(1'b1, edsc_pkg::EDSC_REG_CTRL, 4'hF, 32'h0000_0001);
		repeat (12) @(posedge mclk);
		wb(1'b0, edsc_pkg::EDSC_REG_CTRL, 4'hF, 32'h0);
		chk("busy in scrub", {30'h0, q[edsc_pkg::EDSC_STAT_SCRUBBING], q[edsc_pkg::EDSC_STAT_BUSY]}, 32'h3);
		await_done();
		chk("read after scrub", q, 32'h5A5A_C33C);
		$display("test scrub done");
		// control register through the key series, read back on both dies
		access(32'h6, 19'h0, 32'h0000_00C3);
		access(32'h4, 19'h0, 32'h0);
		chk("ctrl reg die 0", q, 32'h0000_00C3);
		access(32'h14, 19'h0, 32'h0);
		chk("ctrl reg die 1", q, 32'h0000_00C3);
		$display("test control register done");
		// byte lanes, an unmapped offset and the read-only data register
		wb(1'b1, edsc_pkg::EDSC_REG_WDATA, 4'hF, 32'hFFFF_FFFF);
		wb(1'b1, edsc_pkg::EDSC_REG_WDATA, 4'h2, 32'h0);
		wb(1'b0, edsc_pkg::EDSC_REG_WDATA, 4'hF, 32'h0);
		chk("byte lanes", q, 32'hFFFF_00FF);
		wb(1'b1, 4'h2, 4'hF, 32'h0000_00F0);
		wb(1'b0, 4'h2, 4'hF, 32'h0);
		chk("unmapped", q, 32'h0);
		wb(1'b1, edsc_pkg::EDSC_REG_RDATA, 4'hF, 32'h0);
		wb(1'b0, edsc_pkg::EDSC_REG_RDATA, 4'hF, 32'h0);
		chk("rdata read only", q, 32'h0000_00C3);
		$display("test bus done");
		summarize();
	end
	// watchdog well above the few hundred cycles the tests need
	initial begin
		repeat (20000) @(posedge mclk);
		failCount++;
		summarize();
	end
endmodule : tb_top
